// ===== common/counter_bank_if.sv
`timescale 1ns/1ns
`default_nettype none

// Levels to watch go one way, running counts come back.
interface counter_bank_if #(
  parameter int N = 6,
  parameter int W = 20
);
  logic [N-1:0] level;
  logic [W-1:0] count [N];

  modport owner   (output level, input  count);
  modport counter (input  level, output count);
endinterface

`default_nettype wire

// ===== common/readout_bank_map.svh
`ifndef READOUT_BANK_MAP_SVH
`define READOUT_BANK_MAP_SVH

// Register indices; the Wishbone byte address is four times the index.
`define IDX_READOUT_ERR   15'h5112
`define IDX_LIVE_LINES    15'h5114
`define IDX_SNAP_LINES    15'h5115
`define IDX_SEQ_BUSY      15'h5116
`define IDX_EVENT_BUFFER  15'h511b
`define IDX_SW_TRIG       15'h511c
`define IDX_AUX_TRIG      15'h511d
`define IDX_L2_ACCEPT     15'h511e
`define IDX_L2_REJECT     15'h511f
`define IDX_DSTB_A        15'h5120
`define IDX_DSTB_B        15'h5121

// Bus geometry.
`define WB_ADR_W          17
`define WB_DAT_W          32
`define IDX_LSB           2

// Register widths.
`define ERR_W             9
`define LINE_W            8
`define BUSY_W            2
`define BUF_W             10
`define COUNT_W           20

// Readout error bit positions.
`define ERR_SEND_CMD      0
`define ERR_WAIT_TRSF     1
`define ERR_NO_TRSF       2
`define ERR_SHORT_DSTB    3
`define ERR_TRSF_STUCK    4
`define ERR_SCAN_LEN_CMD  5
`define ERR_RECEIVE_LINE  6
`define ERR_CHAN_ADDR     7
`define ERR_BLOCK_LEN     8

// Sequencer status bit positions.
`define BUSY_RUN          0
`define BUSY_FAILED       1

// Event buffer status field widths.
`define BUF_COUNT_W       4
`define BUF_READY_W       4
`define BUF_BLOCK_W       2

// Edge counter channels.
`define NUM_COUNTERS      6
`define CNT_SW            0
`define CNT_AUX           1
`define CNT_L2A           2
`define CNT_L2R           3
`define CNT_DSTB_A        4
`define CNT_DSTB_B        5

`endif

// ===== common/readout_bank_pkg.sv
`default_nettype none
`include "readout_bank_map.svh"

package readout_bank_pkg;

  // Bus line layout shared by the live and snapshot registers, bit 0 last.
  typedef struct packed {
    logic l2;
    logic l1;
    logic trsf_b;
    logic ack_b;
    logic cstb_b;
    logic trsf_a;
    logic ack_a;
    logic cstb_a;
  } bus_lines_s;

  typedef logic [`ERR_W-1:0]    err_t;
  typedef logic [`WB_DAT_W-1:0] word_t;

endpackage

`default_nettype wire

// ===== src/edge_counter_bank.sv
`timescale 1ns/1ns
`default_nettype none

module edge_counter_bank #(
  parameter int N = 6,
  parameter int W = 20
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  counter_bank_if.counter bank
);

  logic [N-1:0] prev;

  if (N < 1 || W < 1 || W > 32) begin : g_bad_size
    $error("edge_counter_bank: N must be at least 1 and W within 1 to 32.");
  end

  // Previous level of every channel, for rising edge detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= '0;
    end else if (ce_i) begin
      prev <= bank.level;
    end
  end

  // One counter per channel; it wraps at its width rather than saturating.
  for (genvar i = 0; i < N; i++) begin : g_cnt
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        bank.count[i] <= '0;
      end else if (ce_i && bank.level[i] && !prev[i]) begin
        bank.count[i] <= bank.count[i] + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== src/readout_status_error_bank.sv
`timescale 1ns/1ns
`default_nettype none
`include "readout_bank_map.svh"

module readout_status_error_bank #(
  parameter int COUNT_W = `COUNT_W
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   ce_i,
  // Wishbone classic slave.
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [`WB_ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [`WB_DAT_W-1:0]   wb_dat_i,
  output logic                        wb_ack_o,
  output logic      [`WB_DAT_W-1:0]   wb_dat_o,
  // Front-end bus pins, asynchronous to clk_i.
  input  wire logic                   cstb_a_i,
  input  wire logic                   ack_a_i,
  input  wire logic                   trsf_a_i,
  input  wire logic                   dstb_a_i,
  input  wire logic                   cstb_b_i,
  input  wire logic                   ack_b_i,
  input  wire logic                   trsf_b_i,
  input  wire logic                   dstb_b_i,
  input  wire logic                   level_one_trigger_i,
  input  wire logic                   level_two_trigger_i,
  // Trigger events from logic on clk_i.
  input  wire logic                   sw_trigger_i,
  input  wire logic                   aux_trigger_i,
  input  wire logic                   level_two_accept_i,
  input  wire logic                   level_two_reject_i,
  // Readout sequencer events on clk_i, each a one-cycle pulse.
  input  wire logic                   readout_start_i,
  input  wire logic                   send_cmd_fail_i,
  input  wire logic                   wait_trsf_error_i,
  input  wire logic                   trsf_missing_i,
  input  wire logic                   short_dstb_i,
  input  wire logic                   trsf_stuck_i,
  input  wire logic                   scan_len_cmd_fail_i,
  input  wire logic                   receive_line_fail_i,
  input  wire logic                   chan_addr_mismatch_i,
  input  wire logic                   block_len_mismatch_i,
  // Instruction sequencer state on clk_i.
  input  wire logic                   seq_busy_i,
  input  wire logic                   seq_done_i,
  input  wire logic                   seq_failed_i,
  // Multi-event buffer state on clk_i.
  input  wire logic [`BUF_COUNT_W-1:0] event_buffer_count_i,
  input  wire logic [`BUF_READY_W-1:0] data_ready_i,
  input  wire logic [`BUF_BLOCK_W-1:0] memory_block_select_i
);

  if (COUNT_W < 1 || COUNT_W > `WB_DAT_W) begin : g_bad_width
    $error("readout_status_error_bank: COUNT_W must lie within 1 to 32.");
  end

  // The map and the package must agree, or the read path slices the wrong bits.
  if ($bits(readout_bank_pkg::bus_lines_s) != `LINE_W) begin : g_bad_lines
    $error("readout_status_error_bank: line layout width mismatch.");
  end

  if ($bits(readout_bank_pkg::err_t) != `ERR_W) begin : g_bad_err
    $error("readout_status_error_bank: error type width mismatch.");
  end

  if (`BUF_COUNT_W + `BUF_READY_W + `BUF_BLOCK_W != `BUF_W) begin : g_bad_buf
    $error("readout_status_error_bank: buffer fields do not fill the register.");
  end

  // Counter channels follow the register order, one index apart.
  if (`IDX_DSTB_B - `IDX_SW_TRIG != `NUM_COUNTERS - 1) begin : g_bad_chan
    $error("readout_status_error_bank: counter indices out of step.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  ////////////////////////////////////////////////////////////////////////////

  localparam int PIN_W = 10;

  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic [PIN_W-1:0] pin_raw;

  // The pins are ordered as the bus line layout, strobes on top.
  assign pin_raw = {dstb_b_i, dstb_a_i, level_two_trigger_i, level_one_trigger_i,
                    trsf_b_i, ack_b_i, cstb_b_i, trsf_a_i, ack_a_i, cstb_a_i};

  // Two stages before any logic looks at a pin; the first stage feeds only the second.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (ce_i) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  readout_bank_pkg::bus_lines_s lines_now;
  logic                         dstb_a_sync;
  logic                         dstb_b_sync;

  assign lines_now   = readout_bank_pkg::bus_lines_s'(pin_sync[`LINE_W-1:0]);
  assign dstb_a_sync = pin_sync[`LINE_W];
  assign dstb_b_sync = pin_sync[`LINE_W+1];

  ////////////////////////////////////////////////////////////////////////////
  // Bus line status
  ////////////////////////////////////////////////////////////////////////////

  readout_bank_pkg::bus_lines_s live_bus_line_status;
  readout_bank_pkg::bus_lines_s transfer_bus_snapshot;

  // The live copy follows the synchronised lines on every enabled clock.
  // With the two synchroniser stages it shows the pins as of three clocks ago.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      live_bus_line_status <= '0;
    end else if (ce_i) begin
      live_bus_line_status <= lines_now;
    end
  end

  // The snapshot holds the last lines seen during a transfer, so software can
  // inspect a stalled transfer after the bus has gone idle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transfer_bus_snapshot <= '0;
    end else if (ce_i && (lines_now.trsf_a || lines_now.trsf_b)) begin
      transfer_bus_snapshot <= lines_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readout errors
  ////////////////////////////////////////////////////////////////////////////

  readout_bank_pkg::err_t err_event;
  readout_bank_pkg::err_t readout_error_flags;

  // Gather the sequencer's error pulses into their bit positions.
  always_comb begin
    err_event                    = '0;
    err_event[`ERR_SEND_CMD]     = send_cmd_fail_i;
    err_event[`ERR_WAIT_TRSF]    = wait_trsf_error_i;
    err_event[`ERR_NO_TRSF]      = trsf_missing_i;
    err_event[`ERR_SHORT_DSTB]   = short_dstb_i;
    err_event[`ERR_TRSF_STUCK]   = trsf_stuck_i;
    err_event[`ERR_SCAN_LEN_CMD] = scan_len_cmd_fail_i;
    err_event[`ERR_RECEIVE_LINE] = receive_line_fail_i;
    err_event[`ERR_CHAN_ADDR]    = chan_addr_mismatch_i;
    err_event[`ERR_BLOCK_LEN]    = block_len_mismatch_i;
  end

  // Flags are sticky; a readout start clears them, but an error in that very
  // cycle still lands, so nothing raised at the start is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      readout_error_flags <= '0;
    end else if (ce_i) begin
      if (readout_start_i) begin
        readout_error_flags <= err_event;
      end else begin
        readout_error_flags <= readout_error_flags | err_event;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and buffer status
  ////////////////////////////////////////////////////////////////////////////

  logic [`BUSY_W-1:0] sequencer_busy_status;
  logic [`BUF_W-1:0]  event_buffer_status;

  logic seq_running;
  logic seq_failed_last;

  // Busy follows the sequencer with one register of delay.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_running <= 1'b0;
    end else if (ce_i) begin
      seq_running <= seq_busy_i;
    end
  end

  // The failure flag is the outcome of the last completed sequence and is
  // kept until the next one completes, so it outlives the idle time between.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_failed_last <= 1'b0;
    end else if (ce_i && seq_done_i) begin
      seq_failed_last <= seq_failed_i;
    end
  end

  // Place both flags at their bit positions.
  always_comb begin
    sequencer_busy_status               = '0;
    sequencer_busy_status[`BUSY_RUN]    = seq_running;
    sequencer_busy_status[`BUSY_FAILED] = seq_failed_last;
  end

  // Buffer state is registered so the read path sees one consistent sample.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_buffer_status <= '0;
    end else if (ce_i) begin
      event_buffer_status <= {memory_block_select_i, data_ready_i, event_buffer_count_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event counters
  ////////////////////////////////////////////////////////////////////////////

  counter_bank_if #(.N(`NUM_COUNTERS), .W(COUNT_W)) cnt_bus ();

  // Triggers come from clk_i logic; strobes only after synchronisation.
  always_comb begin
    cnt_bus.level              = '0;
    cnt_bus.level[`CNT_SW]     = sw_trigger_i;
    cnt_bus.level[`CNT_AUX]    = aux_trigger_i;
    cnt_bus.level[`CNT_L2A]    = level_two_accept_i;
    cnt_bus.level[`CNT_L2R]    = level_two_reject_i;
    cnt_bus.level[`CNT_DSTB_A] = dstb_a_sync;
    cnt_bus.level[`CNT_DSTB_B] = dstb_b_sync;
  end

  edge_counter_bank #(
    .N (`NUM_COUNTERS),
    .W (COUNT_W)
  ) u_counters (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .bank  (cnt_bus.counter)
  );

  logic [COUNT_W-1:0] software_trigger_count;
  logic [COUNT_W-1:0] auxiliary_trigger_count;
  logic [COUNT_W-1:0] level_two_accept_count;
  logic [COUNT_W-1:0] level_two_reject_count;
  logic [COUNT_W-1:0] branch_a_strobe_count;
  logic [COUNT_W-1:0] branch_b_strobe_count;

  // Each running count under its register name.
  assign software_trigger_count  = cnt_bus.count[`CNT_SW];
  assign auxiliary_trigger_count = cnt_bus.count[`CNT_AUX];
  assign level_two_accept_count  = cnt_bus.count[`CNT_L2A];
  assign level_two_reject_count  = cnt_bus.count[`CNT_L2R];
  assign branch_a_strobe_count   = cnt_bus.count[`CNT_DSTB_A];
  assign branch_b_strobe_count   = cnt_bus.count[`CNT_DSTB_B];

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone read path
  ////////////////////////////////////////////////////////////////////////////

  // Widen a counter to a bus word with zero upper bits.
  function automatic readout_bank_pkg::word_t widen_count(input logic [COUNT_W-1:0] value);
    readout_bank_pkg::word_t word;
    word = '0;
    word[COUNT_W-1:0] = value;
    return word;
  endfunction

  logic [`WB_ADR_W-`IDX_LSB-1:0] reg_index;
  readout_bank_pkg::word_t        next_dat;

  assign reg_index = wb_adr_i[`WB_ADR_W-1:`IDX_LSB];

  // Unmapped indices read zero and are still acknowledged.
  always_comb begin
    next_dat = '0;
    if (reg_index == `IDX_READOUT_ERR) begin
      next_dat[`ERR_W-1:0] = readout_error_flags;
    end else if (reg_index == `IDX_LIVE_LINES) begin
      next_dat[`LINE_W-1:0] = live_bus_line_status;
    end else if (reg_index == `IDX_SNAP_LINES) begin
      next_dat[`LINE_W-1:0] = transfer_bus_snapshot;
    end else if (reg_index == `IDX_SEQ_BUSY) begin
      next_dat[`BUSY_W-1:0] = sequencer_busy_status;
    end else if (reg_index == `IDX_EVENT_BUFFER) begin
      next_dat[`BUF_W-1:0] = event_buffer_status;
    end else if (reg_index == `IDX_SW_TRIG) begin
      next_dat = widen_count(software_trigger_count);
    end else if (reg_index == `IDX_AUX_TRIG) begin
      next_dat = widen_count(auxiliary_trigger_count);
    end else if (reg_index == `IDX_L2_ACCEPT) begin
      next_dat = widen_count(level_two_accept_count);
    end else if (reg_index == `IDX_L2_REJECT) begin
      next_dat = widen_count(level_two_reject_count);
    end else if (reg_index == `IDX_DSTB_A) begin
      next_dat = widen_count(branch_a_strobe_count);
    end else if (reg_index == `IDX_DSTB_B) begin
      next_dat = widen_count(branch_b_strobe_count);
    end
  end

  logic take_req;

  // A held request is taken once; the cycle in which ack stands is not a new one.
  assign take_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // One wait state: ack rises the cycle after the request and drops the next.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= take_req;
    end
  end

  // Read data stands from the ack until the next read is taken. Every register
  // is read-only, so writes are acknowledged and discarded.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (ce_i && take_req && !wb_we_i) begin
      wb_dat_o <= next_dat;
    end
  end

endmodule

`default_nettype wire

// ===== tb/frontend_model.sv
`timescale 1ns/1ns
`default_nettype none

// Front-end pair: one branch at a time answers a readout with a burst of strobes.
module frontend_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic       branch_i,
  input  wire logic [3:0] words_i,
  input  wire logic [5:0] idle_i,
  output logic      [5:0] lines_o,
  output logic            dstb_a_o,
  output logic            dstb_b_o,
  output logic            busy_o
);
  logic [4:0] left;
  logic       sel;

  // A burst lasts two cycles per word plus one, so strobes are separated by low cycles.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      left   <= 5'h00;
    end else if (!busy_o && go_i) begin
      busy_o <= 1'b1;
      left   <= {words_i, 1'b0};
      sel    <= branch_i;
    end else if (busy_o) begin
      if (left == 5'h00) busy_o <= 1'b0;
      else left <= left - 5'h01;
    end
  end

  // Outside a burst the lines follow the levels the bench asks for.
  assign lines_o  = !busy_o ? idle_i : (sel ? 6'h38 : 6'h07);
  assign dstb_a_o = busy_o && !sel && left[0];
  assign dstb_b_o = busy_o && sel && left[0];
endmodule

`default_nettype wire

// ===== tb/readout_bank_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "readout_bank_map.svh"

// Watches the register bus of the status bank; register contents are judged on read data.
module readout_bank_assertions #(
  parameter int COUNT_W = 20
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [`WB_ADR_W-1:0] wb_adr_i,
  input  wire logic                 wb_ack_o,
  input  wire logic [`WB_DAT_W-1:0] wb_dat_o,
  input  wire logic                 seq_busy_i
);
  logic [14:0] idx;
  logic        rd;
  logic        busy_q;
  logic [1:0]  stable_cnt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // The address stays valid at the ack edge, so the index names the answer.
  assign idx = wb_adr_i[`WB_ADR_W-1:`IDX_LSB];
  assign rd  = wb_ack_o && !wb_we_i;

  // Busy reads are judged only once the input has settled through the register path.
  always_ff @(posedge clk_i) begin
    busy_q <= seq_busy_i;
    if (rst_i || seq_busy_i != busy_q) stable_cnt <= 2'h0;
    else if (stable_cnt != 2'h3) stable_cnt <= stable_cnt + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && wb_dat_o == '0)
    else $error("bus outputs not cleared by reset");
  a_ack_follows_req: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_one_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_err_width: assert property (rd && idx == `IDX_READOUT_ERR |-> wb_dat_o[31:`ERR_W] == '0)
    else $error("error register has bits above its width");
  a_line_width: assert property (rd && (idx == `IDX_LIVE_LINES || idx == `IDX_SNAP_LINES) |-> wb_dat_o[31:8] == '0)
    else $error("bus line register has bits above its width");
  a_busy_run_bit: assert property (rd && idx == `IDX_SEQ_BUSY && stable_cnt == 2'h3 |-> wb_dat_o[0] == seq_busy_i)
    else $error("busy bit disagrees with sequencer state");
  a_busy_width: assert property (rd && idx == `IDX_SEQ_BUSY |-> wb_dat_o[31:2] == '0)
    else $error("busy register has bits above its width");
  a_buffer_width: assert property (rd && idx == `IDX_EVENT_BUFFER |-> wb_dat_o[31:10] == '0)
    else $error("buffer status has bits above its width");
  a_count_width: assert property (rd && idx >= `IDX_SW_TRIG && idx <= `IDX_DSTB_B |-> (wb_dat_o >> COUNT_W) == '0)
    else $error("counter has bits above its width");
  a_hole_zero: assert property (rd && idx == 15'h5113 |-> wb_dat_o == '0)
    else $error("unmapped index returned data");

  // Main scenarios reached by the bench.
  c_err_read: cover property (rd && idx == `IDX_READOUT_ERR && wb_dat_o != '0);
  c_count_read: cover property (rd && idx == `IDX_DSTB_A && wb_dat_o != '0);
  c_write: cover property (wb_ack_o && wb_we_i);
endmodule

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "readout_bank_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb;
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0, go = 0, br = 0, l1 = 0, l2 = 0;
  logic start = 0, busy = 0, done = 0, failed = 0, a, b;
  logic [16:0] adr = '0;
  logic [3:0]  sel = '0, words = '0, trg = '0, cnt_b = '0, rdy = '0;
  logic [1:0]  blk = '0;
  logic [5:0]  idle = '0, s, q;
  logic [8:0]  err_p = '0, m;
  logic [31:0] wdat = '0, snap = '0;
  wire  [5:0]  lines;
  wire         dsa, dsb, fe_busy, ack;
  wire  [31:0] rdat;
  readout_bank_pkg::word_t d;
  int n_fail = 0, n_tests = 0, k, t;

  readout_status_error_bank #(.COUNT_W(20)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .cstb_a_i(lines[0]), .ack_a_i(lines[1]), .trsf_a_i(lines[2]), .dstb_a_i(dsa), .cstb_b_i(lines[3]),
    .ack_b_i(lines[4]), .trsf_b_i(lines[5]), .dstb_b_i(dsb), .level_one_trigger_i(l1), .level_two_trigger_i(l2),
    .sw_trigger_i(trg[0]), .aux_trigger_i(trg[1]), .level_two_accept_i(trg[2]), .level_two_reject_i(trg[3]),
    .readout_start_i(start), .send_cmd_fail_i(err_p[0]), .wait_trsf_error_i(err_p[1]), .trsf_missing_i(err_p[2]),
    .short_dstb_i(err_p[3]), .trsf_stuck_i(err_p[4]), .scan_len_cmd_fail_i(err_p[5]),
    .receive_line_fail_i(err_p[6]), .chan_addr_mismatch_i(err_p[7]), .block_len_mismatch_i(err_p[8]),
    .seq_busy_i(busy), .seq_done_i(done), .seq_failed_i(failed), .event_buffer_count_i(cnt_b),
    .data_ready_i(rdy), .memory_block_select_i(blk));

  frontend_model FE (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .branch_i(br), .words_i(words), .idle_i(idle),
    .lines_o(lines), .dstb_a_o(dsa), .dstb_b_o(dsb), .busy_o(fe_busy));

  ////////////////////////////////////////////////////////////////////////////////
  // The live and snapshot layouts put both branches low and the triggers on top.
  function automatic logic [31:0] line_exp(input logic [5:0] v, input logic t1, input logic t2);
    return {24'h0, t2, t1, v};
  endfunction

  // One classic cycle; the request stands until ack is sampled high.
  task automatic xfer(input logic [14:0] idx, input logic w, output readout_bank_pkg::word_t r);
    int n;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= $urandom;
    sel  <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    `CHK("ack", 1'b1, ack)
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [14:0] idx, input logic [31:0] e);
    xfer(idx, 1'b0, d);
    `CHK(nm, e, d)
  endtask

  task automatic pulse_err(input logic [8:0] v, input logic st);
    @(posedge clk_i);
    err_p <= v;
    start <= st;
    @(posedge clk_i);
    err_p <= '0;
    start <= 1'b0;
  endtask

  // Reset stands for eight clocks; afterwards every register reads zero.
  task automatic reset_check;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 16; i++) rd_chk("reset value", `IDX_READOUT_ERR + 15'(i), 32'h0);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial forever #10 clk_i = ~clk_i;

  // A hung handshake ends the run through the same report.
  initial begin
    #400000;
    n_fail++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hed29a894));
    reset_check();
    // Two complementary random sets of error pulses reach every flag.
    m = 9'($urandom);
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 9; i++) if (m[i]) pulse_err(9'(1 << i), 1'b0);
      rd_chk("error flags", `IDX_READOUT_ERR, {23'h0, m});
      xfer(`IDX_READOUT_ERR, 1'b1, d);
      rd_chk("error flags held", `IDX_READOUT_ERR, {23'h0, m});
      pulse_err('0, 1'b1);
      rd_chk("error flags cleared", `IDX_READOUT_ERR, 32'h0);
      m = ~m;
    end
    pulse_err(9'h1f0, 1'b0);
    pulse_err(9'h004, 1'b1);
    rd_chk("error with start", `IDX_READOUT_ERR, 32'h4);
    // Random line levels, then a transfer pattern that must stay in the snapshot.
    for (int i = 0; i < 5; i++) begin
      s = 6'($urandom);
      a = 1'($urandom);
      b = 1'($urandom);
      if (i == 3) s = 6'($urandom) | 6'h04;
      if (s[2] || s[5]) snap = line_exp(s, a, b);
      @(posedge clk_i);
      idle <= s;
      l1   <= a;
      l2   <= b;
      repeat (5) @(posedge clk_i);
      rd_chk("live lines", `IDX_LIVE_LINES, line_exp(s, a, b));
      if (i == 4) q = s & 6'h1b;
    end
    @(posedge clk_i);
    idle <= q;
    repeat (5) @(posedge clk_i);
    rd_chk("snapshot", `IDX_SNAP_LINES, snap);
    rd_chk("live after transfer", `IDX_LIVE_LINES, line_exp(q, l1, l2));
    idle <= '0;
    // Sequencer run, then a failed and a clean finish.
    busy <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd_chk("sequencer busy", `IDX_SEQ_BUSY, 32'h1);
    for (int f = 1; f >= 0; f--) begin
      @(posedge clk_i);
      busy   <= 1'b0;
      done   <= 1'b1;
      failed <= 1'(f);
      @(posedge clk_i);
      done <= 1'b0;
      repeat (2) @(posedge clk_i);
      rd_chk("sequencer failed", `IDX_SEQ_BUSY, 32'(f) << 1);
    end
    failed <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd_chk("failed without done", `IDX_SEQ_BUSY, 32'h0);
    failed <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      {blk, rdy, cnt_b} <= 10'($urandom);
      repeat (3) @(posedge clk_i);
      rd_chk("buffer status", `IDX_EVENT_BUFFER, {22'h0, blk, rdy, cnt_b});
    end
    // Trigger edges; the last one is held high and must count once.
    for (int c = 0; c < 4; c++) begin
      k = $urandom_range(6, 1);
      for (int j = 0; j < k; j++) begin
        @(posedge clk_i);
        trg[c] <= 1'b1;
        repeat (j == k - 1 ? 4 : 1) @(posedge clk_i);
        trg[c] <= 1'b0;
      end
      // A rise while the clock enable is low must not count.
      @(posedge clk_i);
      ce_i   <= 1'b0;
      trg[c] <= 1'b1;
      repeat (3) @(posedge clk_i);
      trg[c] <= 1'b0;
      @(posedge clk_i);
      ce_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd_chk("trigger count", `IDX_SW_TRIG + 15'(c), 32'(k));
    end
    // Strobe bursts: the longest on branch A, a random one on branch B.
    for (int i = 0; i < 2; i++) begin
      k = i == 0 ? 15 : $urandom_range(14, 0);
      @(posedge clk_i);
      go    <= 1'b1;
      br    <= 1'(i);
      words <= 4'(k);
      @(posedge clk_i);
      go <= 1'b0;
      t = 0;
      do @(posedge clk_i); while (fe_busy === 1'b1 && t++ < 60);
      repeat (5) @(posedge clk_i);
      rd_chk("strobe count", `IDX_DSTB_A + 15'(i), 32'(k));
    end
    // A second reset in mid-run must clear the counts and sticky flags again.
    {blk, rdy, cnt_b, l1, l2} <= '0;
    rst_i <= 1'b1;
    reset_check();
    final_report();
  end
endmodule

bind readout_status_error_bank readout_bank_assertions #(.COUNT_W(COUNT_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .seq_busy_i(seq_busy_i));

`default_nettype wire
